/* core/erb_defines.vh */
/*
 * shared constants of the energy and rms result bank: clock rate,
 * overflow spans, register addresses, serial command layout, mode bits.
 * assumes it is included by bare name from every design file.
 */
`ifndef ERB_DEFINES_VH
`define ERB_DEFINES_VH

// core clock rate in kHz
`define ERB_CLK_KHZ 40000
// full-scale overflow spans in ms
`define ERB_ACT_OVF_MS 520
`define ERB_REA_OVF_MS 520
`define ERB_APP_OVF_MS 1150
// accumulator steps to overflow at full scale are two to this power
`define ERB_STEP_SHIFT 16

// register addresses, seven bits
`define ERB_ADDR_ACT_A 7'h01
`define ERB_ADDR_ACT_B 7'h02
`define ERB_ADDR_ACT_C 7'h03
`define ERB_ADDR_REA_A 7'h04
`define ERB_ADDR_REA_B 7'h05
`define ERB_ADDR_REA_C 7'h06
`define ERB_ADDR_APP_A 7'h07
`define ERB_ADDR_APP_B 7'h08
`define ERB_ADDR_APP_C 7'h09
`define ERB_ADDR_IRMS_A 7'h0a
`define ERB_ADDR_IRMS_B 7'h0b
`define ERB_ADDR_IRMS_C 7'h0c

// register widths and reset value
`define ERB_ENERGY_W 16
`define ERB_RMS_W 24
`define ERB_RESET_VAL 24'h000000

// serial command byte layout
`define ERB_CMD_BITS 5'h08
`define ERB_CMD_RW_BIT 7
`define ERB_LEN_ENERGY 5'h10
`define ERB_LEN_RMS 5'h18
`define ERB_LEN_NONE 5'h08

// computation mode bits
`define ERB_MODE_ABS_BIT 0
`define ERB_MODE_POS_BIT 1

`endif

/* core/erb_accum.v */
/*
 * one energy accumulator: adds a power sample once per step period
 * into a wide register and shows its top 16 bits as the energy value.
 * assumes the power input is on core_clk and held between updates.
 */
`include "erb_defines.vh"

module erb_accum #(
    parameter SIGNED_ACC = 1,
    parameter [31:0] STEP_CYC = 32'd317
)(
    input wire core_clk,
    input wire rstn,
    input wire [15:0] power,
    output wire [15:0] energy
);

// step divider and wide accumulator with 16 fraction bits
reg [31:0] div_q;
reg [31:0] acc_q;
wire [31:0] ext;
wire [15:0] sign_fill;

assign sign_fill = (SIGNED_ACC != 0) ? {16{power[15]}} : 16'h0000;
assign ext = {sign_fill, power};

////////////////////////////////////////////////////////////////////////
// the fraction bits let a small step period set the overflow span
always @(posedge core_clk or negedge rstn)
begin
    if (!rstn)
    begin
        div_q <= 32'h00000000;
        acc_q <= 32'h00000000;
    end
    else if (div_q >= STEP_CYC - 32'd1)
    begin
        div_q <= 32'h00000000;
        // plain add wraps modulo width, no saturation
        acc_q <= acc_q + ext;
    end
    else
    begin
        div_q <= div_q + 32'd1;
    end
end

assign energy = acc_q[31:16];

endmodule

/* core/erb_top.v */
/*
 * result register bank: nine energy accumulators, three current rms
 * results and the serial read port that returns them to the host.
 * assumes power and rms inputs are on core_clk; the serial pins come
 * from the host, asynchronous, and are synchronised here.
 */
`include "erb_defines.vh"

module erb_top #(
    parameter [31:0] ACT_OVF_CYC = `ERB_ACT_OVF_MS * `ERB_CLK_KHZ,
    parameter [31:0] REA_OVF_CYC = `ERB_REA_OVF_MS * `ERB_CLK_KHZ,
    parameter [31:0] APP_OVF_CYC = `ERB_APP_OVF_MS * `ERB_CLK_KHZ
)(
    input wire core_clk,
    input wire rstn,
    // host serial pins
    input wire sclk,
    input wire cs_n,
    input wire din,
    output reg dout,
    output reg dout_oe,
    // computation mode bits from the mode register
    input wire [1:0] computation_mode_config,
    // per-phase power samples, phase a in the low bits
    input wire [47:0] active_power,
    input wire [47:0] reactive_power,
    input wire [47:0] apparent_power,
    // per-phase current rms results and their update strobe
    input wire [71:0] current_rms,
    input wire current_rms_valid
);

// serial port states
localparam ST_CMD = 2'b00;
localparam ST_READ = 2'b01;
localparam ST_SKIP = 2'b10;

// step periods, never below one cycle
localparam [31:0] ACT_STEP = ((ACT_OVF_CYC >> `ERB_STEP_SHIFT) == 0) ?
    32'd1 : (ACT_OVF_CYC >> `ERB_STEP_SHIFT);
localparam [31:0] REA_STEP = ((REA_OVF_CYC >> `ERB_STEP_SHIFT) == 0) ?
    32'd1 : (REA_OVF_CYC >> `ERB_STEP_SHIFT);
localparam [31:0] APP_STEP = ((APP_OVF_CYC >> `ERB_STEP_SHIFT) == 0) ?
    32'd1 : (APP_OVF_CYC >> `ERB_STEP_SHIFT);

////////////////////////////////////////////////////////////////////////
// shaping of a signed power sample by the mode bits
function [15:0] erb_shape;
    input [15:0] p;
    input [1:0] m;
    begin
        if (m[`ERB_MODE_ABS_BIT] && p[15])
            erb_shape = 16'h0000 - p;  // magnitude accumulation
        else if (m[`ERB_MODE_POS_BIT] && p[15])
            erb_shape = 16'h0000;  // positive-only accumulation
        else
            erb_shape = p;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// accumulators, one set per phase
wire [47:0] act_energy;  // phase a in the low bits
wire [47:0] rea_energy;
wire [47:0] app_energy;

genvar g;
generate
    for (g = 0; g < 3; g = g + 1)
    begin : phase
        erb_accum #(
            .SIGNED_ACC(1),
            .STEP_CYC(ACT_STEP)
        ) u_act (
            .core_clk(core_clk),
            .rstn(rstn),
            .power(erb_shape(active_power[16*g+15:16*g],
                computation_mode_config)),
            .energy(act_energy[16*g+15:16*g])
        );
        erb_accum #(
            .SIGNED_ACC(1),
            .STEP_CYC(REA_STEP)
        ) u_rea (
            .core_clk(core_clk),
            .rstn(rstn),
            .power(erb_shape(reactive_power[16*g+15:16*g],
                computation_mode_config)),
            .energy(rea_energy[16*g+15:16*g])
        );
        // apparent power is a magnitude, so the mode bits leave it alone
        erb_accum #(
            .SIGNED_ACC(0),
            .STEP_CYC(APP_STEP)
        ) u_app (
            .core_clk(core_clk),
            .rstn(rstn),
            .power(apparent_power[16*g+15:16*g]),
            .energy(app_energy[16*g+15:16*g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// current rms results, zero until the first update
reg [71:0] irms_q;

always @(posedge core_clk or negedge rstn)
begin
    if (!rstn)
        irms_q <= {3{`ERB_RESET_VAL}};
    else if (current_rms_valid)
        irms_q <= current_rms;
end

////////////////////////////////////////////////////////////////////////
// pin synchronisers: stage one feeds only stage two
reg [2:0] sclk_q;  // [0] first stage, [2] previous sampled level
reg [1:0] cs_n_q;
reg [1:0] din_q;

always @(posedge core_clk or negedge rstn)
begin
    if (!rstn)
    begin
        sclk_q <= 3'h0;
        cs_n_q <= 2'h3;
        din_q <= 2'h0;
    end
    else
    begin
        sclk_q <= {sclk_q[1], sclk_q[0], sclk};
        cs_n_q <= {cs_n_q[0], cs_n};
        din_q <= {din_q[0], din};
    end
end

wire sclk_rise = sclk_q[1] & ~sclk_q[2];
wire sclk_fall = ~sclk_q[1] & sclk_q[2];
wire cs_idle = cs_n_q[1];
wire din_s = din_q[1];

////////////////////////////////////////////////////////////////////////
// read lookup: address to right-justified value and bit length
reg [23:0] rd_val;
reg [4:0] rd_len;
wire [7:0] cmd_next;

always @*
begin
    rd_val = `ERB_RESET_VAL;
    rd_len = `ERB_LEN_ENERGY;
    case (cmd_next[6:0])
        `ERB_ADDR_ACT_A: rd_val = {8'h00, act_energy[15:0]};
        `ERB_ADDR_ACT_B: rd_val = {8'h00, act_energy[31:16]};
        `ERB_ADDR_ACT_C: rd_val = {8'h00, act_energy[47:32]};
        `ERB_ADDR_REA_A: rd_val = {8'h00, rea_energy[15:0]};
        `ERB_ADDR_REA_B: rd_val = {8'h00, rea_energy[31:16]};
        `ERB_ADDR_REA_C: rd_val = {8'h00, rea_energy[47:32]};
        `ERB_ADDR_APP_A: rd_val = {8'h00, app_energy[15:0]};
        `ERB_ADDR_APP_B: rd_val = {8'h00, app_energy[31:16]};
        `ERB_ADDR_APP_C: rd_val = {8'h00, app_energy[47:32]};
        `ERB_ADDR_IRMS_A:
        begin
            rd_val = irms_q[23:0];
            rd_len = `ERB_LEN_RMS;
        end
        `ERB_ADDR_IRMS_B:
        begin
            rd_val = irms_q[47:24];
            rd_len = `ERB_LEN_RMS;
        end
        `ERB_ADDR_IRMS_C:
        begin
            rd_val = irms_q[71:48];
            rd_len = `ERB_LEN_RMS;
        end
        // other addresses belong elsewhere: one zero byte comes back
        default: rd_len = `ERB_LEN_NONE;
    endcase
end

////////////////////////////////////////////////////////////////////////
// serial port: command bits taken on falls, data driven on rises
reg [1:0] state_q;
reg [7:0] cmd_q;  // command shifter
reg [4:0] cnt_q;  // bits still to shift in this phase
reg [23:0] shift_q;  // snapshot, msb first at bit 23

assign cmd_next = {cmd_q[6:0], din_s};

always @(posedge core_clk or negedge rstn)
begin
    if (!rstn)
    begin
        state_q <= ST_CMD;
        cmd_q <= 8'h00;
        cnt_q <= `ERB_CMD_BITS;
        shift_q <= `ERB_RESET_VAL;
        dout <= 1'b0;
        dout_oe <= 1'b0;
    end
    else if (cs_idle)
    begin
        // chip select high aborts and releases the data line
        state_q <= ST_CMD;
        cnt_q <= `ERB_CMD_BITS;
        dout_oe <= 1'b0;
    end
    else
    begin
        case (state_q)
            ST_CMD:
            begin
                if (sclk_fall)
                begin
                    cmd_q <= cmd_next;
                    if (cnt_q == 5'h01)
                    begin
                        if (!cmd_next[`ERB_CMD_RW_BIT])
                        begin
                            // whole value taken at once
                            shift_q <= rd_val << (`ERB_LEN_RMS - rd_len);
                            cnt_q <= rd_len;
                            state_q <= ST_READ;
                        end
                        else
                        begin
                            // writes are not ours; wait for deselect
                            state_q <= ST_SKIP;
                        end
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
            end
            ST_READ:
            begin
                if (sclk_rise && cnt_q != 5'h00)
                begin
                    dout <= shift_q[23];
                    dout_oe <= 1'b1;
                    shift_q <= {shift_q[22:0], 1'b0};
                    cnt_q <= cnt_q - 5'h01;
                end
                else if (sclk_fall && cnt_q == 5'h00)
                begin
                    // release after the last pulse, back to command mode
                    dout_oe <= 1'b0;
                    cnt_q <= `ERB_CMD_BITS;
                    state_q <= ST_CMD;
                end
            end
            ST_SKIP:
            begin
                dout_oe <= 1'b0;
            end
            default:
            begin
                state_q <= ST_CMD;
                cnt_q <= `ERB_CMD_BITS;
            end
        endcase
    end
end

endmodule

/* dv/erb_top_monitor.sv */
/* port checker of the serial read port of the result bank.
   assumes sclk and cs_n only move on core_clk edges. */
module erb_top_monitor (
    input wire core_clk,
    input wire rstn,
    input wire sclk,
    input wire cs_n,
    input wire dout,
    input wire dout_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////
    // output is quiet when reset lets go
    a_reset_quiet: assert property (
        $rose(rstn) |-> !dout_oe && !dout)
        else $error("serial output active after reset");
    // data bits move only shortly after a link clock rise
    a_dout_on_rise: assert property (
        dout_oe && $past(dout_oe) && $changed(dout)
        |-> $past(sclk) && !$past(sclk, 5))
        else $error("data bit moved away from a clock rise");
    a_oe_on_rise: assert property (
        $rose(dout_oe) |-> $past(sclk) && !$past(sclk, 5)
        && !$past(cs_n, 4))
        else $error("output enabled without a selected rise");
    a_oe_off_fall: assert property (
        $fell(dout_oe) |-> !$past(sclk) || $past(cs_n))
        else $error("output released without fall or deselect");
    a_oe_needs_cs: assert property (
        dout_oe |-> !$past(cs_n, 4))
        else $error("output still driven after deselect");
    a_cs_idle: assert property (
        cs_n [*4] |-> !dout_oe)
        else $error("output driven while deselected");
    // without link activity the enable may not move
    a_quiet_hold: assert property (
        ($stable(sclk) && $stable(cs_n)) [*5] |-> $stable(dout_oe))
        else $error("enable moved with no link activity");
    // a fresh command takes eight falls, so no quick re-enable
    a_fall_quiet: assert property (
        $fell(dout_oe) |-> (!dout_oe) [*8])
        else $error("output re-enabled too soon");
endmodule
bind erb_top erb_top_monitor i_mon (
    .core_clk(core_clk),
    .rstn(rstn),
    .sclk(sclk),
    .cs_n(cs_n),
    .dout(dout),
    .dout_oe(dout_oe)
);

/* dv/erb_host.sv */
/* host model on the serial read port of the result bank.
   assumes core_clk paces it; link period is eight core cycles. */
module erb_host (
    input wire core_clk,
    input wire dout,
    input wire dout_oe,
    output logic sclk,
    output logic cs_n,
    output logic din
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////
    // idle: deselected with the clock parked high
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // half a link period
    task automatic half();
        repeat (4) @(posedge core_clk);
    endtask
    // command byte, then n data bits captured msb first
    task automatic rd(input logic [7:0] cmd, input int n,
                      output logic [23:0] q);
        q = 24'h000000;
        cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            din <= cmd[i];
            half();
            sclk <= 1'b0;
            half();
            if (i > 0)
                sclk <= 1'b1;
        end
        for (int i = 0; i < n; i++)
        begin
            // din is not listened to now, so keep it moving
            din <= ~din;
            half();
            sclk <= 1'b1;
            half();
            // a released line reads as the inverse of its last level
            q = {q[22:0], dout_oe ? dout : ~dout};
            sclk <= 1'b0;
        end
        half();
        cs_n <= 1'b1;
        sclk <= 1'b1;
        half();
    endtask
endmodule

/* dv/erb_top_tb.sv */
/* self-checking bench of the result bank through its serial port.
   assumes overflow spans cut to 65536 so each cycle is one step. */
module erb_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk, cs_n, din, dout, dout_oe;
    logic [1:0] mode = 2'h0;
    logic [47:0] act = 48'h0;
    logic [47:0] rea = 48'h0;
    logic [47:0] app = 48'h0;
    logic [71:0] rms = 72'h0;
    logic rms_vld = 1'b0;
    logic [23:0] q;
    int n_fail = 0;
    int n_checks = 0;
    always #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////
    erb_top #(.ACT_OVF_CYC(32'd65536), .REA_OVF_CYC(32'd65536),
        .APP_OVF_CYC(32'd65536)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe),
        .computation_mode_config(mode), .active_power(act),
        .reactive_power(rea), .apparent_power(app),
        .current_rms(rms), .current_rms_valid(rms_vld));
    erb_host i_host (.core_clk(core_clk), .dout(dout),
        .dout_oe(dout_oe), .sclk(sclk), .cs_n(cs_n), .din(din));
    task automatic report_and_stop();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // read a register and compare; length follows its address
    // a nonzero cut deselects after that many data bits
    task automatic chk(input logic [6:0] a, input logic [23:0] e,
                       input int cut = 0);
        int n;
        n = (a == 7'h00 || a > 7'h0c) ? 8 : (a > 7'h09 ? 24 : 16);
        if (cut > 0)
            n = cut;
        i_host.rd({1'b0, a}, n, q);
        n_checks++;
        if (q !== e)
        begin
            n_fail++;
            $display("[ERR] reg %h exp %h got %h", a, e, q);
        end
    endtask
    // samples stand for exactly k cycles, then drop to zero
    task automatic burst(input logic [47:0] a, r, p, input int k);
        act <= a;
        rea <= r;
        app <= p;
        repeat (k) @(posedge core_clk);
        act <= 48'h0;
        rea <= 48'h0;
        app <= 48'h0;
    endtask
    task automatic load_rms(input logic [71:0] v);
        rms <= v;
        rms_vld <= 1'b1;
        @(posedge core_clk);
        rms_vld <= 1'b0;
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int a = 0; a <= 12; a++)
            chk(7'(a), 24'h000000);
        burst(48'h4000, 48'hc000_0000, 48'hc000_0000_0000, 8);
        chk(7'h01, 24'h000002);
        chk(7'h05, 24'h00fffe);
        chk(7'h09, 24'h000006);
        mode <= 2'h2;
        burst(48'h0, 48'hc000, 48'h0, 8);
        chk(7'h04, 24'h000000);
        mode <= 2'h1;
        burst(48'hc000_0000, 48'h0, 48'h0, 8);
        chk(7'h02, 24'h000002);
        // a write command is ignored, the next read still works
        i_host.rd(8'h81, 16, q);
        chk(7'h01, 24'h000002);
        load_rms(72'h0a0b0c_ffffff_123456);
        chk(7'h0a, 24'h123456);
        // a read cut after one byte; the next read must still work
        chk(7'h0a, 24'h000012, 8);
        chk(7'h0c, 24'h0a0b0c);
        // new rms lands mid-read; the read must keep the old value
        fork
            chk(7'h0b, 24'hffffff);
            begin
                repeat (120) @(posedge core_clk);
                load_rms(72'h0);
            end
        join
        // full scale past the span: active turns negative, apparent wraps
        burst(48'h7fff, 48'h0, 48'hffff, 65539);
        chk(7'h01, 24'h008002);
        chk(7'h07, 24'h000001);
        // a second reset in mid-run clears the accumulators again
        rstn <= 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(7'h01, 24'h000000);
        chk(7'h09, 24'h000000);
        report_and_stop();
    end
    // watchdog sized well above the expected run
    initial
    begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        $display("[ERR] run exp done got hang");
        report_and_stop();
    end
endmodule
